// ===== pkg/sdir_pkg.sv
// Constants for the spatial direction index decoder.
// Assumes angles in signed fixed point, ANG_SCALE units per degree.
package sdir_pkg;
  // Fixed point: 1 LSB = 1/64 degree
  localparam int ANG_W = 16;
  localparam int ANG_SCALE = 64;
  localparam int HALF_TURN = 180 * ANG_SCALE;
  localparam int FULL_TURN = 360 * ANG_SCALE;
  localparam int IDX_W = 16;
  localparam int GRID_W = 5;
  localparam int MAX_GRID = 11;
  localparam int WIDE_GRID = 16;
  localparam int SLOPE_FRAC = 8;
  // Elevation step in degrees, per grid bit count 0..16
  localparam int ELEV_STEP_DEG [0:16] = '{0, 0, 0, 45, 45, 30, 30, 20,
    15, 12, 10, 9, 0, 0, 0, 0, 5};
  // Log2 of point count on the zero-elevation circle, per grid bit count
  localparam int EQ_LOG2 [0:16] = '{0, 1, 2, 2, 3, 4, 5, 6, 7, 8, 9, 10,
    0, 0, 0, 0, 15};
  // Elevation at or above this selects the second break set (degrees)
  localparam int DECOMP_SEL_DEG = 30;
  // Input and output breakpoints of the piecewise-linear decompander
  localparam int DECOMPAND_INPUT_BREAKS [0:1][0:5] = '{
    '{0, 30, 60, 90, 135, 180}, '{0, 45, 90, 120, 150, 180}};
  localparam int DECOMPAND_OUTPUT_BREAKS [0:1][0:5] = '{
    '{0, 20, 45, 80, 130, 180}, '{0, 30, 70, 110, 145, 180}};
  // Segment slopes, output span over input span, SLOPE_FRAC fraction bits
  localparam int DECOMP_SLOPE [0:1][0:4] = '{
    '{171, 213, 299, 284, 284}, '{171, 228, 341, 299, 299}};
  // Controller states, Gray coded from ST_IDLE via ST_SEARCH, ST_AZIM and ST_DECOMP to ST_PUSH
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEARCH = 3'h1,
    ST_AZIM = 3'h3,
    ST_DECOMP = 3'h2,
    ST_PUSH = 3'h6
  } dec_state_t;
  typedef enum logic [1:0] {
    TB_IDLE = 2'h0,
    TB_MAIN = 2'h1,
    TB_EXTRA = 2'h3
  } tb_state_t;
endpackage

// ===== rtl/spatial_direction_index_decoder.sv
// Spatial direction decoder: truncated-binary bit reader plus spherical
// index deindexer and angle dequantizer with a two-entry output buffer.
// Assumes upstream logic on ref_clk; bits arrive MSB first.
//
// Overview of operation
// RQ1: Each dequantization takes index and grid bits
// RQ2: Zero-bit grid gives zero elevation and azimuth
// RQ3: One-bit grid: azimuth 0 or -180 degrees
// RQ4: Two-bit grid: zero elevation, generic azimuth path
// RQ5: Enumerate equator, then alternating positive, negative circles
// RQ6: Support grids of 1 to 11 and 16 bits
// RQ7: Upper mode: consecutive nonnegative circles only
// RQ8: Search cumulative offsets, sign from upper/lower circle
// RQ9: Circle number is elevation, remainder is azimuth index
// RQ10: Elevation equals signed index times grid step
// RQ11: Azimuth index times step plus shift, wrapped
// RQ12: Upper mode decompands absolute azimuth piecewise-linearly
// RQ13: Breakpoint set chosen by dequantized elevation
// RQ14: Decompanded azimuth keeps its original sign
// RQ15: Truncated binary: floor log2 width, threshold, extra bit
// RQ16: Every index accepted maps to one angle pair
// RQ17: Parser holds inputs until handshake, MSB first
// RQ18: Fixed-point angles, result flagged valid once
`timescale 1ns/1ps
module spatial_direction_index_decoder
  import sdir_pkg::*;
#(
  parameter int IDX_BITS = IDX_W,
  parameter int SYM_BITS = 16
) (
  input wire logic ref_clk, // Clock, 25 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic upper_hemisphere_mode, // Upper-hemisphere-only grids
  input wire logic idxValid, // Spherical index offered
  input wire logic [IDX_BITS-1:0] idxIn, // Spherical index
  input wire logic [GRID_W-1:0] gridBits, // Grid bit count
  output logic idxReady, // Index accepted when high with idxValid
  output logic angValid, // Angle pair available
  output logic signed [ANG_W-1:0] elevation, // Elevation, 1/64 degree
  output logic signed [ANG_W-1:0] azimuth, // Azimuth, 1/64 degree
  input wire logic angReady, // Renderer takes the pair
  input wire logic tbReq, // Truncated-binary read request
  input wire logic [SYM_BITS-1:0] tbSize, // Alphabet size, at least 1
  output logic tbBusy, // Reader busy
  input wire logic bitValid, // Bitstream bit offered
  input wire logic bitIn, // Bitstream bit
  output logic bitReady, // Bit consumed when high with bitValid
  output logic tbDone, // One-cycle pulse, symbol decoded
  output logic [SYM_BITS-1:0] tbValue // Decoded symbol
);

  // Floor of log2 for the reader width
  function automatic logic [4:0] floor_log2(input logic [SYM_BITS-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < SYM_BITS; i++) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Points per circle as log2, shrinking one step per circle
  function automatic logic [4:0] circ_log2(input logic [4:0] l0,
                                           input logic [4:0] c);
    return (c >= l0) ? 5'h00 : 5'(l0 - c);
  endfunction

  // Truncated-binary reader state and working registers
  tb_state_t tbState;
  logic [4:0] tbLeft;
  logic [SYM_BITS:0] tbAcc;
  logic [SYM_BITS:0] tbThresh;
  // Width, threshold and accumulator with the new bit shifted in
  wire logic [4:0] tbWidth = floor_log2(tbSize); // [RQ15]
  wire logic [SYM_BITS+1:0] tbThreshCalc =
    ((SYM_BITS+2)'(1) << (tbWidth + 5'h01)) - (SYM_BITS+2)'(tbSize);
  wire logic bitTake = bitReady && bitValid; // [RQ17]
  wire logic [SYM_BITS:0] tbShift = {tbAcc[SYM_BITS-1:0], bitIn};
  wire logic tbMainEnd = (tbState == TB_MAIN) && bitTake &&
    (tbLeft == 5'h01);
  wire logic tbNeedExtra = tbShift >= tbThresh; // [RQ15]
  wire logic [SYM_BITS:0] tbExtraVal = tbShift - tbThresh; // [RQ15]

  // Reader sequencing: read width bits, then maybe one more
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tbState <= TB_IDLE;
      tbLeft <= 5'h00;
      tbAcc <= '0;
      tbThresh <= '0;
      tbDone <= 1'b0;
      tbValue <= '0;
      tbBusy <= 1'b0;
      bitReady <= 1'b0;
    end else if (ce) begin
      tbDone <= 1'b0;
      case (tbState)
        TB_IDLE: begin
          if (tbReq) begin
            tbThresh <= tbThreshCalc[SYM_BITS:0];
            tbAcc <= '0;
            tbLeft <= tbWidth;
            if (tbWidth == 5'h00) begin
              tbValue <= '0; // Size one: no bits, value zero
              tbDone <= 1'b1;
            end else begin
              tbState <= TB_MAIN;
              tbBusy <= 1'b1;
              bitReady <= 1'b1;
            end
          end
        end
        TB_MAIN: begin
          if (bitTake) begin
            tbAcc <= tbShift;
            tbLeft <= tbLeft - 5'h01;
            if (tbMainEnd && !tbNeedExtra) begin
              tbValue <= tbShift[SYM_BITS-1:0]; // [RQ15]
              tbDone <= 1'b1;
              tbState <= TB_IDLE;
              tbBusy <= 1'b0;
              bitReady <= 1'b0;
            end else if (tbMainEnd) begin
              tbState <= TB_EXTRA; // [RQ15]
            end
          end
        end
        TB_EXTRA: begin
          if (bitTake) begin
            tbValue <= tbExtraVal[SYM_BITS-1:0]; // [RQ15]
            tbDone <= 1'b1;
            tbState <= TB_IDLE;
            tbBusy <= 1'b0;
            bitReady <= 1'b0;
          end
        end
        default: begin
          tbState <= TB_IDLE;
          tbBusy <= 1'b0;
          bitReady <= 1'b0;
        end
      endcase
    end
  end

  // Deindexer: held request, circle search state and results
  dec_state_t state;
  logic [IDX_BITS-1:0] idxHold;
  logic [4:0] gridHold;
  logic upperHold;
  logic [4:0] circ; // Absolute circle number
  logic lowerSide; // Circle currently tested is the negative one
  logic [IDX_BITS:0] offset; // Cumulative offset before tested circle
  logic negElev;
  logic [IDX_BITS-1:0] azIdx;
  logic signed [ANG_W-1:0] elevRes;
  logic signed [ANG_W-1:0] azRes;

  // Supported grid sizes; any other count behaves as the zero grid
  wire logic gridOk = (gridBits <= GRID_W'(MAX_GRID)) ||
    (gridBits == GRID_W'(WIDE_GRID)); // [RQ6]
  wire logic [4:0] gridEff = gridOk ? gridBits : 5'h00;
  // Size of the circle under test and the running offset
  wire logic [4:0] l0 = 5'(EQ_LOG2[gridHold]);
  wire logic [4:0] circLog = circ_log2(l0, circ);
  wire logic [IDX_BITS:0] circPts = (IDX_BITS+1)'(1) << circLog;
  wire logic [IDX_BITS:0] nextOff = offset + circPts; // [RQ8]
  wire logic found = {1'b0, idxHold} < nextOff; // [RQ8]
  wire logic lastCirc = circ >= gridHold; // Guard against overrun
  // Upper mode walks circles in order, else equator, +1, -1, +2, -2
  wire logic nextLower = !upperHold && (circ != 5'h00) && !lowerSide;
  wire logic [4:0] nextCirc = nextLower ? circ : circ + 5'h01; // [RQ5] [RQ7]
  // Remainder inside the found circle is the azimuth index
  wire logic [IDX_BITS:0] azIdxCalc = {1'b0, idxHold} - offset; // [RQ9]

  // Generic azimuth: index times step plus odd-circle half step
  wire logic [IDX_BITS+15:0] azProd =
    (IDX_BITS+16)'(azIdx) * (IDX_BITS+16)'(FULL_TURN);
  wire logic [IDX_BITS+15:0] azBase = azProd >> circLog; // [RQ11]
  wire logic [IDX_BITS+15:0] azShift = circ[0] ?
    ((IDX_BITS+16)'(FULL_TURN) >> (circLog + 5'h01)) : '0; // [RQ11]
  wire logic [IDX_BITS+15:0] azSum = azBase + azShift;
  // Fold into the half-open range around zero
  wire logic [IDX_BITS+15:0] azWrap =
    (azSum >= (IDX_BITS+16)'(HALF_TURN)) ?
    azSum - (IDX_BITS+16)'(FULL_TURN) : azSum; // [RQ11]
  wire logic signed [ANG_W-1:0] azGeneric = ANG_W'(azWrap);

  // Elevation: circle times grid step, signed by hemisphere
  wire logic [ANG_W-1:0] elevStep =
    ANG_W'(ELEV_STEP_DEG[gridHold] * ANG_SCALE);
  wire logic [ANG_W-1:0] elevMag = ANG_W'(circ * elevStep); // [RQ10]
  wire logic signed [ANG_W-1:0] elevGeneric =
    negElev ? -$signed(elevMag) : $signed(elevMag); // [RQ10]

  // Decompander: break set from elevation, segment from abs azimuth
  wire logic azNeg = azRes < 0;
  wire logic [ANG_W-1:0] azAbs = azNeg ? ANG_W'(-azRes) : ANG_W'(azRes);
  wire logic [ANG_W-1:0] elAbs = elevRes[ANG_W-1] ? ANG_W'(-elevRes) :
    ANG_W'(elevRes);
  wire logic breakSet = elAbs >= ANG_W'(DECOMP_SEL_DEG * ANG_SCALE); // [RQ13]
  // Lowest segment whose upper break covers the magnitude
  logic [2:0] seg;
  always_comb begin
    seg = 3'h4;
    for (int k = 4; k >= 0; k--) begin
      if (azAbs <= ANG_W'(DECOMPAND_INPUT_BREAKS[breakSet][k+1] *
          ANG_SCALE)) begin
        seg = 3'(k); // [RQ12]
      end
    end
  end
  // Interpolate from the lower break; fraction truncated
  wire logic [ANG_W-1:0] segIn =
    ANG_W'(DECOMPAND_INPUT_BREAKS[breakSet][seg] * ANG_SCALE);
  wire logic [ANG_W-1:0] segOut =
    ANG_W'(DECOMPAND_OUTPUT_BREAKS[breakSet][seg] * ANG_SCALE);
  wire logic [ANG_W+8:0] segSlope = (ANG_W+9)'(DECOMP_SLOPE[breakSet][seg]);
  wire logic [ANG_W+8:0] segProd =
    (ANG_W+9)'(azAbs - segIn) * segSlope; // [RQ12]
  wire logic [ANG_W-1:0] decompAbs =
    segOut + ANG_W'(segProd >> SLOPE_FRAC); // [RQ12]
  wire logic signed [ANG_W-1:0] decompRes =
    azNeg ? -$signed(decompAbs) : $signed(decompAbs); // [RQ14]

  // Two-entry output buffer: head drives the ports, spare catches stalls
  logic spareValid;
  logic signed [ANG_W-1:0] spareElev;
  logic signed [ANG_W-1:0] spareAz;
  // Decoder waits in PUSH while both entries are taken
  wire logic pop = angValid && angReady;
  wire logic bufFull = angValid && spareValid;
  wire logic push = (state == ST_PUSH) && !bufFull; // [RQ18]

  // Index accept and result computation
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      idxHold <= '0;
      gridHold <= 5'h00;
      upperHold <= 1'b0;
      circ <= 5'h00;
      lowerSide <= 1'b0;
      offset <= '0;
      negElev <= 1'b0;
      azIdx <= '0;
      elevRes <= '0;
      azRes <= '0;
      idxReady <= 1'b0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          idxReady <= 1'b1;
          if (idxReady && idxValid) begin // [RQ1] [RQ17]
            idxReady <= 1'b0;
            idxHold <= idxIn;
            gridHold <= gridEff;
            upperHold <= upper_hemisphere_mode;
            circ <= 5'h00;
            lowerSide <= 1'b0;
            offset <= '0;
            negElev <= 1'b0;
            elevRes <= '0;
            azRes <= '0;
            if (gridEff == 5'h00) begin
              state <= ST_PUSH; // [RQ2]
            end else if (gridEff == 5'h01) begin
              azRes <= idxIn[0] ? -ANG_W'(HALF_TURN) : '0; // [RQ3]
              state <= ST_PUSH;
            end else if (gridEff == 5'h02) begin
              azIdx <= idxIn; // [RQ4]
              state <= ST_AZIM;
            end else begin
              state <= ST_SEARCH; // [RQ5]
            end
          end
        end
        ST_SEARCH: begin
          if (found || lastCirc) begin
            negElev <= lowerSide; // [RQ8]
            azIdx <= azIdxCalc[IDX_BITS-1:0]; // [RQ9]
            state <= ST_AZIM;
          end else begin
            offset <= nextOff; // [RQ8]
            circ <= nextCirc;
            lowerSide <= nextLower;
          end
        end
        ST_AZIM: begin
          elevRes <= elevGeneric; // [RQ9] [RQ10]
          azRes <= azGeneric; // [RQ11]
          state <= upperHold ? ST_DECOMP : ST_PUSH; // [RQ12]
        end
        ST_DECOMP: begin
          azRes <= decompRes; // [RQ12] [RQ14]
          state <= ST_PUSH;
        end
        ST_PUSH: begin
          if (!bufFull) begin
            state <= ST_IDLE; // [RQ16]
          end
        end
        default: begin
          state <= ST_IDLE;
          idxReady <= 1'b0;
        end
      endcase
    end
  end

  // Output buffer: head register feeds the ports directly
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      angValid <= 1'b0;
      elevation <= '0;
      azimuth <= '0;
      spareValid <= 1'b0;
      spareElev <= '0;
      spareAz <= '0;
    end else if (ce) begin
      if (!angValid || pop) begin
        angValid <= spareValid || push; // [RQ18]
        elevation <= spareValid ? spareElev : elevRes;
        azimuth <= spareValid ? spareAz : azRes;
        spareValid <= spareValid && push;
        if (spareValid && push) begin
          spareElev <= elevRes;
          spareAz <= azRes;
        end
      end else if (push) begin
        spareValid <= 1'b1;
        spareElev <= elevRes;
        spareAz <= azRes;
      end
    end
  end

endmodule

// ===== verification/sdir_monitor.sv
// Port checker for the spatial direction index decoder.
// Assumes ce high while results are checked.
`timescale 1ns/1ps
module sdir_monitor
  import sdir_pkg::*;
#(
  parameter int IDX_BITS = IDX_W,
  parameter int SYM_BITS = 16
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Enable
  input wire logic upper_hemisphere_mode, // Mode
  input wire logic idxValid, // Offer
  input wire logic [IDX_BITS-1:0] idxIn, // Index
  input wire logic [GRID_W-1:0] gridBits, // Grid
  input wire logic idxReady, // Accept
  input wire logic angValid, // Result
  input wire logic signed [ANG_W-1:0] elevation, // Elevation
  input wire logic signed [ANG_W-1:0] azimuth, // Azimuth
  input wire logic angReady, // Pop
  input wire logic tbReq, // Read
  input wire logic [SYM_BITS-1:0] tbSize, // Size
  input wire logic tbBusy, // Busy
  input wire logic tbDone, // Done
  input wire logic [SYM_BITS-1:0] tbValue // Value
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Index taken while the output buffer is empty
  sequence s_take(int g);
    idxValid && idxReady && ce && !angValid && gridBits == g;
  endsequence
  sequence s_quiet(int n);
    !angValid [*2];
  endsequence
  chk_zero_grid: assert property (
    s_take(0) |=> !angValid ##1 angValid && elevation == 0 && azimuth == 0)
    else $error("zero grid result wrong");
  chk_one_bit: assert property (s_take(1) |-> ##2 angValid &&
    elevation == 0 && azimuth == ($past(idxIn[0], 2) ? -HALF_TURN : 0))
    else $error("one bit grid result wrong");
  chk_two_bit: assert property (
    s_take(2) ##0 !upper_hemisphere_mode |=> s_quiet(2) ##1
    angValid && elevation == 0)
    else $error("two bit grid result wrong");
  chk_two_upper: assert property (
    s_take(2) ##0 upper_hemisphere_mode |=> s_quiet(2) ##1 !angValid ##1
    angValid && elevation == 0)
    else $error("two bit upper result wrong");
  chk_ready_drop: assert property (
    idxValid && idxReady && ce |=> !idxReady)
    else $error("second index taken in flight");
  chk_result_hold: assert property (angValid && !angReady |=>
    angValid && $stable(elevation) && $stable(azimuth))
    else $error("stalled result changed");
  chk_azim_range: assert property (
    angValid |-> azimuth >= -HALF_TURN && azimuth < HALF_TURN)
    else $error("azimuth out of range");
  chk_unit_read: assert property (
    tbReq && !tbBusy && tbSize == 1 |=> tbDone && tbValue == 0)
    else $error("unit alphabet read wrong");
  chk_read_start: assert property (
    tbReq && !tbBusy && tbSize > 1 |=> tbBusy && !tbDone)
    else $error("reader did not start");
endmodule
bind spatial_direction_index_decoder sdir_monitor #(
  .IDX_BITS(IDX_BITS), .SYM_BITS(SYM_BITS)) u_sdir_monitor (
  .ref_clk(ref_clk), .rst(rst), .ce(ce),
  .upper_hemisphere_mode(upper_hemisphere_mode), .idxValid(idxValid),
  .idxIn(idxIn), .gridBits(gridBits), .idxReady(idxReady),
  .angValid(angValid), .elevation(elevation), .azimuth(azimuth),
  .angReady(angReady), .tbReq(tbReq), .tbSize(tbSize), .tbBusy(tbBusy),
  .tbDone(tbDone), .tbValue(tbValue));

// ===== verification/bit_source_model.sv
// Bitstream parser model feeding the truncated-binary reader.
// Assumes the bench fills q; slow inserts random gaps.
`timescale 1ns/1ps
module bit_source_model (
  input wire logic ref_clk, // Clock
  input wire logic slow, // Random gaps
  input wire logic bitReady, // Consumed
  output logic bitValid, // Offer
  output logic bitIn // Bit
);
  bit q[$];
  initial begin
    bitValid = 0;
    bitIn = 0;
  end
  // Offer next bit MSB first; idle line toggles, never stale
  always @(negedge ref_clk) begin
    if (!bitValid && q.size() > 0 && (!slow || $urandom % 2)) begin
      bitValid = 1;
      bitIn = q[0];
    end else if (!bitValid) begin
      bitIn = ~bitIn;
    end
  end
  // Bit held until the reader takes it
  always @(posedge ref_clk) begin
    if (bitValid && bitReady) begin
      void'(q.pop_front());
      bitValid <= 0;
    end
  end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the spatial direction index decoder.
// Assumes a 25 MHz clock and the bit source model as parser.
`timescale 1ns/1ps
module testbench
  import sdir_pkg::*;
;
  logic ref_clk, rst, ce, upper_hemisphere_mode, idxValid, idxReady;
  logic angValid, angReady, tbReq, tbBusy, bitValid, bitIn, bitReady;
  logic tbDone, slow;
  logic [IDX_W-1:0] idxIn;
  logic [GRID_W-1:0] gridBits;
  logic signed [ANG_W-1:0] elevation, azimuth;
  logic [15:0] tbSize, tbValue;
  int n_mismatch, comparisons, cycles, stall;
  int expQ[$];
  localparam int SZ [0:5] = '{1, 2, 3, 5, 64, 65535};
  spatial_direction_index_decoder u_spatial_direction_index_decoder (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .upper_hemisphere_mode(upper_hemisphere_mode), .idxValid(idxValid),
    .idxIn(idxIn), .gridBits(gridBits), .idxReady(idxReady),
    .angValid(angValid), .elevation(elevation), .azimuth(azimuth),
    .angReady(angReady), .tbReq(tbReq), .tbSize(tbSize), .tbBusy(tbBusy),
    .bitValid(bitValid), .bitIn(bitIn), .bitReady(bitReady),
    .tbDone(tbDone), .tbValue(tbValue));
  bit_source_model u_bit_source_model (.ref_clk(ref_clk), .slow(slow),
    .bitReady(bitReady), .bitValid(bitValid), .bitIn(bitIn));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Angle pair against the two oldest expectations
  task automatic cmp_pair(input logic [31:0] el, input logic [31:0] az);
    cmp(el, expQ.pop_front());
    cmp(az, expQ.pop_front());
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Expected pair: circle search, step, shift, decompanding
  function automatic void model(input int b, idx, input bit up,
      output int el, az);
    int p, c, off, n, st, a, s, k;
    el = 0;
    az = 0;
    off = 0;
    if (b == 1) begin
      az = idx ? -HALF_TURN : 0;
    end else if (b >= 2 && (b <= MAX_GRID || b == WIDE_GRID)) begin
      for (p = 0; p < 64; p++) begin
        c = up ? p : (p + 1) / 2;
        n = 1 << (EQ_LOG2[b] > c ? EQ_LOG2[b] - c : 0);
        if (idx < off + n) break;
        off += n;
      end
      st = FULL_TURN / (2 * n);
      el = (!up && p % 2 == 0 && p > 0 ? -c : c) * ELEV_STEP_DEG[b] * 64;
      az = (idx - off) * FULL_TURN / n + (c % 2 ? st : 0);
      if (az >= HALF_TURN) az -= FULL_TURN;
      if (up) begin
        a = az < 0 ? -az : az;
        s = el >= DECOMP_SEL_DEG * ANG_SCALE;
        k = 0;
        while (k < 4 && a > DECOMPAND_INPUT_BREAKS[s][k + 1] * 64) k++;
        a = DECOMPAND_OUTPUT_BREAKS[s][k] * 64 + (((a -
          DECOMPAND_INPUT_BREAKS[s][k] * 64) * DECOMP_SLOPE[s][k]) >> 8);
        az = az < 0 ? -a : a;
      end
    end
  endfunction
  task automatic send(input int b, idx, input bit up);
    int el, az, t;
    model(b, idx, up, el, az);
    @(negedge ref_clk);
    idxValid = 1;
    idxIn = idx[IDX_W-1:0];
    gridBits = b[GRID_W-1:0];
    upper_hemisphere_mode = up;
    for (t = 0; t < 300 && !idxReady; t++) @(negedge ref_clk);
    @(posedge ref_clk);
    expQ.push_back(el);
    expQ.push_back(az);
    @(negedge ref_clk);
    idxValid = 0;
  endtask
  task automatic rd(input int s);
    int v, w, th, u, nb, i, t;
    v = $urandom % s;
    w = $clog2(s + 1) - 1;
    th = (1 << (w + 1)) - s;
    u = v < th ? v : v + th;
    nb = v < th ? w : w + 1;
    for (i = nb - 1; i >= 0; i--) u_bit_source_model.q.push_back(u[i]);
    @(negedge ref_clk);
    tbReq = 1;
    tbSize = s[15:0];
    @(negedge ref_clk);
    tbReq = 0;
    for (t = 0; t < 400 && !tbDone; t++) @(negedge ref_clk);
    cmp(tbValue, v);
    cmp(u_bit_source_model.q.size(), 0);
  endtask
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Renderer: always, randomly or never ready
  always @(negedge ref_clk)
    angReady <= stall == 0 || stall == 1 && $urandom % 2;
  // Each popped pair against the oldest expectation
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end else if (!rst && ce && angValid && angReady) begin
      cmp_pair(elevation, azimuth);
    end
  end
  initial begin
    int i, b, n, u;
    void'($urandom(66));
    {rst, ce, angReady, idxValid, tbReq, upper_hemisphere_mode, slow} = 7'h70;
    {idxIn, gridBits, tbSize, stall} = 0;
    {n_mismatch, comparisons, cycles} = 0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 0;
    send(0, 5, 0);
    send(1, 1, 1);
    send(12, 3, 0);
    send(16, 0, 1);
    send(16, $urandom % 65536, 0);
    for (i = 0; i < 4; i++) send(2, i, i % 2);
    // Drain, then fill both buffer entries plus one in flight
    for (i = 0; i < 300 && expQ.size() > 0; i++) @(negedge ref_clk);
    stall = 2;
    for (i = 0; i < 3; i++) send(1, i % 2, 0);
    repeat (10) @(negedge ref_clk);
    cmp({angValid, idxReady}, 2);
    // Enable low: a ready renderer must not drain the frozen buffer
    ce = 0;
    stall = 0;
    repeat (4) @(negedge ref_clk);
    cmp({angValid, idxReady}, 2);
    ce = 1;
    stall = 1;
    for (i = 0; i < 40; i++) begin
      b = 3 + $urandom % 9;
      u = $urandom % 2;
      n = u ? 7 << (EQ_LOG2[b] - 2) : 2 << EQ_LOG2[b];
      send(b, $urandom % n, u);
    end
    for (i = 0; i < 300 && expQ.size() > 0; i++) @(negedge ref_clk);
    cmp(expQ.size(), 0);
    foreach (SZ[i]) rd(SZ[i]);
    slow = 1;
    for (i = 0; i < 20; i++) rd(1 + $urandom % 300);
    complete_run();
  end
endmodule
